//--- logic/meal_pkg.sv
// Purpose: Constants for the extrema, power and alert block
// Assumes: 16-bit registers on an 8-bit word address
// Notes:   Offsets, field positions and reset values live here
package meal_pkg;
  // ==========================================================
  // Register word addresses
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_VLIM   = 8'h01;
  localparam logic [7:0] A_TLIM   = 8'h02;
  localparam logic [7:0] A_SLIM   = 8'h03;
  localparam logic [7:0] A_THERM  = 8'h08;
  localparam logic [7:0] A_AVGT   = 8'h16;
  localparam logic [7:0] A_TEXT   = 8'h1A;
  localparam logic [7:0] A_IEXT   = 8'h1C;
  localparam logic [7:0] A_CFG    = 8'h1D;
  localparam logic [7:0] A_THERMISTOR_GAIN  = 8'h2C;
  localparam logic [7:0] A_THERMISTOR_OFFSET   = 8'h2D;
  localparam logic [7:0] A_DIE    = 8'h34;
  localparam logic [7:0] A_PWR    = 8'hB1;
  localparam logic [7:0] A_APWR   = 8'hB3;
  localparam logic [7:0] A_ILIM   = 8'hB4;
  localparam logic [7:0] A_CURVE  = 8'hB9;
  localparam logic [7:0] A_CFG2   = 8'hBB;
  localparam int         SN_WORDS = 8;
  localparam logic [7:0] A_SN [SN_WORDS] = '{8'hD4, 8'hD5, 8'hD9,
    8'hDA, 8'hDC, 8'hDD, 8'hDE, 8'hDF};
  // ==========================================================
  // Reset values
  localparam logic [15:0] R_STATUS = 16'h8082;
  localparam logic [15:0] R_EXT    = 16'h807F;
  localparam logic [15:0] R_VLIM   = 16'hFF00;
  localparam logic [15:0] R_TLIM   = 16'h7F80;
  localparam logic [15:0] R_SLIM   = 16'hFF00;
  localparam logic [15:0] R_ILIM   = 16'h7F80;
  localparam logic [15:0] R_CFG    = 16'h0000;
  localparam logic [15:0] R_CFG2   = 16'h00C0;
  localparam logic [15:0] R_THERMISTOR_GAIN  = 16'h4000;
  localparam logic [15:0] R_ZERO   = 16'h0000;
  localparam logic [15:0] ST_VALID = 16'hFFCE;
  // ==========================================================
  // Status fields
  localparam int ST_POR = 1;
  localparam int ST_IMN = 2;
  localparam int ST_BST = 3;
  localparam int ST_IMX = 6;
  localparam int ST_DSOC = 7;
  localparam int ST_VMN = 8;
  localparam int ST_TMN = 9;
  localparam int ST_SMN = 10;
  localparam int ST_BI = 11;
  localparam int ST_VMX = 12;
  localparam int ST_TMX = 13;
  localparam int ST_SMX = 14;
  localparam int ST_BR = 15;
  localparam logic [15:0] ST_THR = 16'h7746;
  // ==========================================================
  // Configuration fields
  localparam int CF_BER = 0;
  localparam int CF_BEI = 1;
  localparam int CF_AEN = 2;
  localparam int CF_IS = 11;
  localparam int CF_VS = 12;
  localparam int CF_TS = 13;
  localparam int CF_SS = 14;
  localparam int CF_THERMAL_SOURCE_SELECT = 15;
  localparam int C2_CHARGE_STEP_ALERT_ENABLE = 5;
  localparam int C2_ATRATE = 6;
  localparam int C2_DYNAMIC_POWER_ENABLE = 7;
  localparam int SOC_STEP_BIT = 8;
  // ==========================================================
  // Arithmetic scaling and timing
  localparam int GAIN_SHIFT = 14;
  localparam int CURVE_SHIFT = 6;
  localparam int PWR_LSB = 16;
  localparam int CLK_HZ = 20_000_000;
  localparam int THERM_PERIOD_US = 1000;
  localparam int THERM_PERIOD_CYC = THERM_PERIOD_US * (CLK_HZ / 1_000_000);
  // ==========================================================
  // Thermistor sequencer states
  typedef enum logic [1:0] {
    TH_WAIT = 2'b01,
    TH_CONV = 2'b10
  } meal_th_t;
endpackage

//--- logic/meal_top.sv
// Purpose: Extrema trackers, thermal source, power, threshold alerts
// Assumes: Measurement inputs synchronous to i_clk with valid strobes
// Notes:   Alert pin is open drain, enable high pulls the line low
`timescale 1ns/10ps
// Contract
// - Current extrema resets to 807F, max byte 80, min byte 7F.
// - Each current sample raises max or lowers min when beyond them.
// - Writing 807F to either extrema register restarts that tracker.
// - Current extrema are signed bytes, max high, twice threshold step.
// - Thermal extrema preset 80/7F, signed 1 degree bytes, max high.
// - Source select 0 picks die sensor, 1 picks thermistor; reset 0.
// - Thermistor pullup connects periodically, released after conversion.
// - Gain, offset, curve shape thermistor result only, never die.
// - Selected output follows source; die output always die sensor.
// - Instant and filtered power from current and voltage.
// - Alert output only pulls low; high comes from external pullup.
// - Removal and insertion alerts gated by their own enables.
// - Threshold alerts raised only while global alert enable is 1.
// - Charge step alert when reported charge bit 8 changes.
// - Insertion and removal flags persist until host clears them.
// - Per class choice between software clear and automatic clear.
// - Voltage limits upper/lower bytes, 20mV steps, reset FF00.
// - Thermal limits signed bytes, 1 degree steps, reset 7F80.
// - Charge limits upper/lower bytes, 1 percent steps, reset FF00.
// - Current limits signed bytes, reset 7F80.
// - Both enables clear puts 128-bit serial on those outputs.
// - Min and max flags set when reading crosses the limits.
module meal_top
  import meal_pkg::*;
#(
  parameter int           AVG_SHIFT     = 4,
  parameter int           THERM_PERIOD  = meal_pkg::THERM_PERIOD_CYC,
  // Arbitrary serial value
  parameter logic [127:0] SERIAL_NUMBER =
    128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // Register port
  input  wire logic [7:0]   i_reg_addr,
  input  wire logic         i_reg_wr,
  input  wire logic         i_reg_rd,
  input  wire logic [15:0]  i_reg_wdata,
  output logic      [15:0]  o_reg_rdata,
  output logic              o_reg_rvalid,
  // Measurements
  input  wire logic         i_meas_valid,
  input  wire logic [15:0]  i_current,
  input  wire logic [15:0]  i_cell_voltage_reading,
  input  wire logic         i_die_valid,
  input  wire logic [15:0]  i_die_thermal,
  input  wire logic         i_charge_valid,
  input  wire logic [15:0]  i_reported_charge_pct,
  input  wire logic [127:0] i_dynamic_words,
  // Battery detect comparators
  input  wire logic         i_removal_cmp,
  input  wire logic         i_insert_cmp,
  // Thermistor converter
  input  wire logic         i_therm_done,
  input  wire logic [15:0]  i_therm_ratio,
  output logic              o_thermistor_pin_pullup,
  // Alert pin
  output logic              o_alert_out_n_o,
  output logic              o_alert_out_n_oe
);
  import meal_pkg::*;

  // ==========================================================
  // Parameter checks
  if (AVG_SHIFT < 1 || AVG_SHIFT > 8) begin : g_chk_avg
    $error("AVG_SHIFT out of range");
  end
  if (THERM_PERIOD < 2) begin : g_chk_per
    $error("THERM_PERIOD too short");
  end

  // ==========================================================
  // Registers and locals
  logic [15:0] status_reg, status_next, st_set;
  logic [15:0] vlim_reg, tlim_reg, slim_reg, ilim_reg;
  logic [15:0] cfg_reg, cfg2_reg, thermistor_gain_reg, thermistor_offset_reg, curve_reg;
  logic [15:0] iext_reg, text_reg;
  logic [15:0] volt_reg, curr_reg, charge_reg;
  logic [15:0] thermal_reg, die_reg, avgt_reg, therm_res_reg;
  logic [15:0] pwr_reg, apwr_reg, rd_next;
  logic        rem_reg, ins_reg, pending;
  logic [31:0] th_cnt_reg;
  meal_th_t    th_state_reg;
  logic        wr_status, wr_iext, wr_text, sn_mode, thermal_source_select;
  logic        th_done_evt, t_upd, dsoc_chg;
  logic [15:0] t_new, th_val, cv_sx;
  logic signed [32:0] th_prod, pw_prod;
  logic signed [16:0] cv_prod;
  logic [7:0]  ibyte, vbyte, tbyte, sbyte, iext_in;

  assign wr_status = i_reg_wr && i_reg_addr == A_STATUS;
  assign wr_iext   = i_reg_wr && i_reg_addr == A_IEXT;
  assign wr_text   = i_reg_wr && i_reg_addr == A_TEXT;
  assign thermal_source_select      = cfg_reg[CF_THERMAL_SOURCE_SELECT];
  assign sn_mode   = !cfg2_reg[C2_ATRATE] && !cfg2_reg[C2_DYNAMIC_POWER_ENABLE];

  // ==========================================================
  // Extrema update helper
  function automatic logic [15:0] meal_track(input logic [15:0] e,
                                             input logic [7:0]  s);
    logic [7:0] mx;
    logic [7:0] mn;
    mx = ($signed(s) > $signed(e[15:8])) ? s : e[15:8];
    mn = ($signed(s) < $signed(e[7:0])) ? s : e[7:0];
    return {mx, mn};
  endfunction

  // ==========================================================
  // Configuration and limit registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      vlim_reg  <= R_VLIM;
      tlim_reg  <= R_TLIM;
      slim_reg  <= R_SLIM;
      ilim_reg  <= R_ILIM;
      cfg_reg   <= R_CFG;
      cfg2_reg  <= R_CFG2;
      thermistor_gain_reg <= R_THERMISTOR_GAIN;
      thermistor_offset_reg  <= R_ZERO;
      curve_reg <= R_ZERO;
    end else if (i_reg_wr) begin
      unique case (i_reg_addr)
        A_VLIM:  vlim_reg  <= i_reg_wdata;
        A_TLIM:  tlim_reg  <= i_reg_wdata;
        A_SLIM:  slim_reg  <= i_reg_wdata;
        A_ILIM:  ilim_reg  <= i_reg_wdata;
        A_CFG:   cfg_reg   <= i_reg_wdata;
        A_CFG2:  cfg2_reg  <= i_reg_wdata;
        A_THERMISTOR_GAIN: thermistor_gain_reg <= i_reg_wdata;
        A_THERMISTOR_OFFSET:  thermistor_offset_reg  <= i_reg_wdata;
        A_CURVE: curve_reg <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Latest readings
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      volt_reg   <= R_ZERO;
      curr_reg   <= R_ZERO;
      charge_reg <= R_ZERO;
      rem_reg    <= 1'b0;
      ins_reg    <= 1'b0;
    end else begin
      rem_reg <= i_removal_cmp;
      ins_reg <= i_insert_cmp;
      if (i_meas_valid) begin
        volt_reg <= i_cell_voltage_reading;
        curr_reg <= i_current;
      end
      if (i_charge_valid) begin
        charge_reg <= i_reported_charge_pct;
      end
    end
  end

  // ==========================================================
  // Thermistor sequencer
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      th_state_reg            <= TH_WAIT;
      th_cnt_reg              <= '0;
      o_thermistor_pin_pullup <= 1'b0;
      therm_res_reg           <= R_ZERO;
    end else begin
      unique case (th_state_reg)
        TH_WAIT: begin
          if (!thermal_source_select) begin
            th_cnt_reg <= '0;
          end else if (th_cnt_reg == 32'(THERM_PERIOD - 1)) begin
            th_cnt_reg              <= '0;
            th_state_reg            <= TH_CONV;
            o_thermistor_pin_pullup <= 1'b1;
          end else begin
            th_cnt_reg <= th_cnt_reg + 32'h1;
          end
        end
        TH_CONV: begin
          if (i_therm_done) begin
            th_state_reg            <= TH_WAIT;
            o_thermistor_pin_pullup <= 1'b0;
            therm_res_reg           <= th_val;
          end
        end
        default: th_state_reg <= TH_WAIT;
      endcase
    end
  end

  // Ratio to temperature through gain, offset and curve
  always_comb begin
    th_prod = $signed({1'b0, i_therm_ratio}) * $signed(thermistor_gain_reg);
    cv_prod = $signed(curve_reg[7:0]) * $signed({1'b0, i_therm_ratio[15:8]});
    cv_sx   = 16'(cv_prod >>> CURVE_SHIFT);
    th_val  = th_prod[GAIN_SHIFT +: 16] + thermistor_offset_reg + cv_sx;
  end

  assign th_done_evt = th_state_reg == TH_CONV && i_therm_done;
  assign t_upd = thermal_source_select ? th_done_evt : i_die_valid;
  assign t_new = thermal_source_select ? th_val : i_die_thermal;

  // ==========================================================
  // Thermal outputs
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      thermal_reg <= R_ZERO;
      die_reg     <= R_ZERO;
      avgt_reg    <= R_ZERO;
    end else begin
      if (i_die_valid) begin
        die_reg <= i_die_thermal;
      end
      if (t_upd) begin
        thermal_reg <= t_new;
        avgt_reg <= avgt_reg + 16'($signed(t_new - avgt_reg) >>> AVG_SHIFT);
      end
    end
  end

  // ==========================================================
  // Power
  assign pw_prod = $signed(i_current) *
                   $signed({1'b0, i_cell_voltage_reading});
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pwr_reg  <= R_ZERO;
      apwr_reg <= R_ZERO;
    end else if (i_meas_valid) begin
      pwr_reg  <= pw_prod[PWR_LSB +: 16];
      apwr_reg <= apwr_reg +
        16'($signed(pw_prod[PWR_LSB +: 16] - apwr_reg) >>> AVG_SHIFT);
    end
  end

  // ==========================================================
  // Extrema trackers
  assign iext_in = {i_current[15], i_current[15:9]};
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      iext_reg <= R_EXT;
      text_reg <= R_EXT;
    end else begin
      if (wr_iext) begin
        iext_reg <= i_reg_wdata;
      end else if (i_meas_valid) begin
        iext_reg <= meal_track(iext_reg, iext_in);
      end
      if (wr_text) begin
        text_reg <= i_reg_wdata;
      end else if (t_upd) begin
        text_reg <= meal_track(text_reg, t_new[15:8]);
      end
    end
  end

  // ==========================================================
  // Threshold compare and status
  assign vbyte = volt_reg[15:8];
  assign tbyte = thermal_reg[15:8];
  assign sbyte = charge_reg[15:8];
  assign ibyte = curr_reg[15:8];
  assign dsoc_chg = i_charge_valid && (i_reported_charge_pct[SOC_STEP_BIT]
                    != charge_reg[SOC_STEP_BIT]);

  always_comb begin
    st_set = '0;
    st_set[ST_VMX] = vbyte > vlim_reg[15:8];
    st_set[ST_VMN] = vbyte < vlim_reg[7:0];
    st_set[ST_TMX] = $signed(tbyte) > $signed(tlim_reg[15:8]);
    st_set[ST_TMN] = $signed(tbyte) < $signed(tlim_reg[7:0]);
    st_set[ST_SMX] = sbyte > slim_reg[15:8];
    st_set[ST_SMN] = sbyte < slim_reg[7:0];
    st_set[ST_IMX] = $signed(ibyte) > $signed(ilim_reg[15:8]);
    st_set[ST_IMN] = $signed(ibyte) < $signed(ilim_reg[7:0]);
    st_set[ST_BR]  = i_removal_cmp && !rem_reg;
    st_set[ST_BI]  = i_insert_cmp && !ins_reg;
    st_set[ST_DSOC] = dsoc_chg;
  end

  always_comb begin
    status_next = status_reg;
    if (wr_status) begin
      status_next = status_reg & i_reg_wdata;
    end
    status_next = status_next | st_set;
    if (!cfg_reg[CF_VS]) begin
      status_next[ST_VMX] = st_set[ST_VMX];
      status_next[ST_VMN] = st_set[ST_VMN];
    end
    if (!cfg_reg[CF_TS]) begin
      status_next[ST_TMX] = st_set[ST_TMX];
      status_next[ST_TMN] = st_set[ST_TMN];
    end
    if (!cfg_reg[CF_SS]) begin
      status_next[ST_SMX] = st_set[ST_SMX];
      status_next[ST_SMN] = st_set[ST_SMN];
    end
    if (!cfg_reg[CF_IS]) begin
      status_next[ST_IMX] = st_set[ST_IMX];
      status_next[ST_IMN] = st_set[ST_IMN];
    end
    status_next[ST_BST] = i_removal_cmp;
    status_next = status_next & ST_VALID;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      status_reg <= R_STATUS;
    end else begin
      status_reg <= status_next;
    end
  end

  // ==========================================================
  // Alert pin
  assign pending = (cfg_reg[CF_BER] && status_reg[ST_BR]) ||
                   (cfg_reg[CF_BEI] && status_reg[ST_BI]) ||
                   (cfg_reg[CF_AEN] && |(status_reg & ST_THR)) ||
                   (cfg2_reg[C2_CHARGE_STEP_ALERT_ENABLE] && status_reg[ST_DSOC]);
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_alert_out_n_o  <= 1'b0;
      o_alert_out_n_oe <= 1'b0;
    end else begin
      o_alert_out_n_oe <= pending;
    end
  end

  // ==========================================================
  // Register read
  always_comb begin
    rd_next = R_ZERO;
    unique case (i_reg_addr)
      A_STATUS: rd_next = status_reg;
      A_VLIM:   rd_next = vlim_reg;
      A_TLIM:   rd_next = tlim_reg;
      A_SLIM:   rd_next = slim_reg;
      A_THERM:  rd_next = thermal_reg;
      A_AVGT:   rd_next = avgt_reg;
      A_TEXT:   rd_next = text_reg;
      A_IEXT:   rd_next = iext_reg;
      A_CFG:    rd_next = cfg_reg;
      A_THERMISTOR_GAIN:  rd_next = thermistor_gain_reg;
      A_THERMISTOR_OFFSET:   rd_next = thermistor_offset_reg;
      A_DIE:    rd_next = die_reg;
      A_PWR:    rd_next = pwr_reg;
      A_APWR:   rd_next = apwr_reg;
      A_ILIM:   rd_next = ilim_reg;
      A_CURVE:  rd_next = curve_reg;
      A_CFG2:   rd_next = cfg2_reg;
      default:  rd_next = R_ZERO;
    endcase
    for (int i = 0; i < SN_WORDS; i++) begin
      if (i_reg_addr == A_SN[i]) begin
        rd_next = sn_mode ? SERIAL_NUMBER[16*i +: 16]
                          : i_dynamic_words[16*i +: 16];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_reg_rdata  <= R_ZERO;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= rd_next;
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_conv_end;
    o_thermistor_pin_pullup && i_therm_done;
  endsequence

  a_curr_ext_reset: assert property (disable iff (1'b0)
    !i_rst_n |=> iext_reg == R_EXT && text_reg == R_EXT)
    else $error("extrema not preset");
  a_curr_max_track: assert property (
    i_meas_valid && !wr_iext && $signed(iext_in) > $signed(iext_reg[15:8])
    |=> iext_reg[15:8] == $past(iext_in))
    else $error("current max missed");
  a_ext_restart: assert property (
    wr_text && i_reg_wdata == R_EXT |=> text_reg == R_EXT)
    else $error("thermal tracker not restarted");
  a_die_follow: assert property (
    !thermal_source_select && i_die_valid |=> thermal_reg == die_reg)
    else $error("die and selected differ");
  a_pullup_release: assert property (
    s_conv_end |=> !o_thermistor_pin_pullup [*2])
    else $error("pullup stays on");
  a_alert_follow: assert property (
    pending |=> o_alert_out_n_oe && !o_alert_out_n_o)
    else $error("alert not driven");
  a_alert_gate: assert property (
    !cfg_reg[CF_AEN] && !cfg_reg[CF_BER] && !cfg_reg[CF_BEI] &&
    !cfg2_reg[C2_CHARGE_STEP_ALERT_ENABLE] |=> !o_alert_out_n_oe)
    else $error("alert without enable");
  a_br_sticky: assert property (
    status_reg[ST_BR] && !(wr_status && !i_reg_wdata[ST_BR])
    |=> status_reg[ST_BR])
    else $error("removal flag lost");
  a_dsoc_set: assert property (
    dsoc_chg |=> status_reg[ST_DSOC])
    else $error("charge step flag missed");
  a_serial_mode: assert property (
    sn_mode && i_reg_rd && i_reg_addr == A_SN[0]
    |=> o_reg_rvalid && o_reg_rdata == SERIAL_NUMBER[15:0])
    else $error("serial word wrong");
endmodule

//--- dv/meal_host.sv
// Purpose: Host model for the register strobes and the alert line
// Assumes: Strobes change on the falling edge, one request at a time
// Notes:   Alert line resolved with an external pullup
`timescale 1ns/10ps
module meal_host (
  // Clock
  input  wire logic        i_clk,
  // Register port
  output logic      [7:0]  o_addr,
  output logic             o_wr,
  output logic             o_rd,
  output logic      [15:0] o_wdata,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_rvalid,
  // Alert pin
  input  wire logic        i_alert_o,
  input  wire logic        i_alert_oe,
  output logic             o_alert_line
);
  // ==========================================================
  // Open drain line, pullup gives the high level
  assign o_alert_line = i_alert_oe ? i_alert_o : 1'b1;
  initial begin
    o_addr  = 8'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_wdata = 16'h0000;
  end
  // ==========================================================
  // Register cycles
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge i_clk);
    o_addr  = a;
    o_wdata = d;
    o_wr    = 1'b1;
    @(negedge i_clk);
    o_wr    = 1'b0;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d,
                    output logic v);
    @(negedge i_clk);
    o_addr = a;
    o_rd   = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    d    = i_rdata;
    v    = i_rvalid;
  endtask
endmodule

//--- dv/test_measurement_extrema_alert_logic.sv
// Purpose: Random and corner checks of extrema, power, alerts, serial
// Assumes: Inputs driven on the falling edge
// Notes:   Short thermistor period for simulation
`timescale 1ns/10ps
module test_measurement_extrema_alert_logic;
  import meal_pkg::*;
  // Arbitrary serial value
  localparam logic [127:0] SN_VAL =
    128'hA5A5_0F0F_1234_5678_9ABC_DEF0_C3C3_3C3C;
  logic               i_clk, i_rst_n, wr, rd, rv, mv, dv, rm, td, pu;
  logic               ao, aoe, al, gv, ins, cv;
  logic        [7:0]  adr;
  logic        [15:0] wd, rdat, cur, volt, die, ratio, got, pw, c;
  logic        [15:0] ap, at, chg;
  logic        [127:0] dyn;
  logic signed [31:0] prod;
  logic signed [7:0]  mx, mn, b;
  int                 n_errors, samples_checked, seed, i;

  initial i_clk = 1'b0;
  always #25 i_clk = ~i_clk;

  meal_top #(.THERM_PERIOD(8), .SERIAL_NUMBER(SN_VAL)) DUT (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_addr(adr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wd), .o_reg_rdata(rdat),
    .o_reg_rvalid(rv), .i_meas_valid(mv), .i_current(cur),
    .i_cell_voltage_reading(volt), .i_die_valid(dv), .i_die_thermal(die),
    .i_charge_valid(cv), .i_reported_charge_pct(chg),
    .i_dynamic_words(dyn), .i_removal_cmp(rm), .i_insert_cmp(ins),
    .i_therm_done(td), .i_therm_ratio(ratio),
    .o_thermistor_pin_pullup(pu), .o_alert_out_n_o(ao),
    .o_alert_out_n_oe(aoe));
  meal_host host (.i_clk(i_clk), .o_addr(adr), .o_wr(wr), .o_rd(rd),
    .o_wdata(wd), .i_rdata(rdat), .i_rvalid(rv), .i_alert_o(ao),
    .i_alert_oe(aoe), .o_alert_line(al));

  // ==========================================================
  // Checking and stimulus tasks
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    host.rd(a, got, gv);
    chk({15'h0000, gv}, 16'h0001);
    chk(got, e);
  endtask
  task automatic achk(input logic e);
    chk({15'h0000, al}, {15'h0000, e});
  endtask
  task automatic meas(input logic [15:0] x);
    @(negedge i_clk);
    cur  = x;
    volt = 16'($random(seed)) & 16'h7FFF;
    prod = $signed(x) * $signed({1'b0, volt});
    pw   = prod[31:16];
    ap   = ap + 16'($signed(pw - ap) >>> 4);
    mv   = 1'b1;
    @(negedge i_clk);
    mv = 1'b0;
    repeat (3) @(negedge i_clk);
  endtask
  task automatic finish_test;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge i_clk);
    n_errors++;
    finish_test;
  end

  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'hACA19C08;
    n_errors = 0;
    samples_checked = 0;
    i_rst_n = 1'b0;
    {mv, dv, rm, td, ins, cv} = 6'h00;
    {cur, volt, die, ratio} = 64'h0;
    {ap, at, chg} = 48'h0;
    dyn = {$random(seed), $random(seed), $random(seed), $random(seed)};
    repeat (6) @(negedge i_clk);
    i_rst_n = 1'b1;
    rchk(A_VLIM, 16'hFF00);
    rchk(A_TLIM, 16'h7F80);
    rchk(A_SLIM, 16'hFF00);
    rchk(A_ILIM, 16'h7F80);
    rchk(A_IEXT, 16'h807F);
    rchk(A_TEXT, 16'h807F);
    rchk(8'h05, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      mx = 8'sh80;
      mn = 8'sh7F;
      for (i = 0; i < 10; i++) begin
        c = (i == 3) ? 16'h8000 : (i == 4) ? 16'h7FFF : 16'($random(seed));
        meas(c);
        b = {c[15], c[15:9]};
        if (b > mx) mx = b;
        if (b < mn) mn = b;
        rchk(A_IEXT, {mx, mn});
        rchk(A_PWR, pw);
        rchk(A_APWR, ap);
      end
      host.wr(A_IEXT, R_EXT);
      rchk(A_IEXT, R_EXT);
    end
    mx = 8'sh80;
    mn = 8'sh7F;
    for (i = 0; i < 6; i++) begin
      c = 16'($random(seed));
      @(negedge i_clk);
      die = c;
      dv  = 1'b1;
      @(negedge i_clk);
      dv = 1'b0;
      repeat (3) @(negedge i_clk);
      b = c[15:8];
      at = at + 16'($signed(c - at) >>> 4);
      rchk(A_AVGT, at);
      if (b > mx) mx = b;
      if (b < mn) mn = b;
      rchk(A_THERM, c);
      rchk(A_DIE, c);
      rchk(A_TEXT, {mx, mn});
    end
    host.wr(A_CFG, 16'h8000);
    for (i = 0; i < 40 && pu !== 1'b1; i++) @(negedge i_clk);
    chk({15'h0000, pu}, 16'h0001);
    ratio = 16'($random(seed));
    td = 1'b1;
    @(negedge i_clk);
    td = 1'b0;
    @(negedge i_clk);
    chk({15'h0000, pu}, 16'h0000);
    rchk(A_DIE, c);
    rchk(A_THERM, ratio);
    host.wr(A_CFG, 16'h0000);
    host.wr(A_STATUS, 16'h0000);
    host.wr(A_ILIM, 16'h10F0);
    meas(16'h2000);
    achk(1'b1);
    host.wr(A_CFG, 16'h0004);
    meas(16'h2000);
    achk(1'b0);
    host.rd(A_STATUS, got, gv);
    chk({15'h0000, got[ST_IMX]}, 16'h0001);
    meas(16'h0500);
    achk(1'b1);
    meas(16'hE000);
    achk(1'b0);
    host.rd(A_STATUS, got, gv);
    chk({15'h0000, got[ST_IMN]}, 16'h0001);
    host.wr(A_CFG, 16'h0804);
    meas(16'h0500);
    achk(1'b0);
    host.wr(A_STATUS, 16'h0000);
    repeat (3) @(negedge i_clk);
    achk(1'b1);
    host.wr(A_CFG, 16'h0000);
    rm = 1'b1;
    repeat (4) @(negedge i_clk);
    achk(1'b1);
    rm = 1'b0;
    host.wr(A_CFG, 16'h0001);
    repeat (3) @(negedge i_clk);
    achk(1'b0);
    host.wr(A_STATUS, 16'h0000);
    repeat (3) @(negedge i_clk);
    achk(1'b1);
    host.wr(A_CFG, 16'h0002);
    ins = 1'b1;
    repeat (4) @(negedge i_clk);
    achk(1'b0);
    ins = 1'b0;
    host.wr(A_STATUS, 16'h0000);
    repeat (3) @(negedge i_clk);
    achk(1'b1);
    host.wr(A_CFG, 16'h0000);
    host.wr(A_CFG2, 16'h00E0);
    for (i = 0; i < 2; i++) begin
      @(negedge i_clk);
      chg = (i == 0) ? 16'h0080 : 16'h0100;
      cv  = 1'b1;
      @(negedge i_clk);
      cv = 1'b0;
      repeat (3) @(negedge i_clk);
      achk(i == 1 ? 1'b0 : 1'b1);
    end
    host.wr(A_STATUS, 16'h0000);
    repeat (3) @(negedge i_clk);
    achk(1'b1);
    host.wr(A_CFG2, 16'h0000);
    for (i = 0; i < SN_WORDS; i++) rchk(A_SN[i], SN_VAL[16*i +: 16]);
    host.wr(A_CFG2, 16'h00C0);
    for (i = 0; i < SN_WORDS; i++) rchk(A_SN[i], dyn[16*i +: 16]);
    finish_test;
  end
endmodule
